// ### rtl/sss_sequencer.v
// sequencer and host bus of the four-channel simultaneous sampler
`default_nettype none
`include "sss_defs.vh"
module sss_sequencer
(
  input  wire                      ref_clk,
  input  wire                      arst_n,
  input  wire                      sample_strobe_n,
  input  wire                      chipSel_n,
  input  wire                      write_n,
  input  wire                      read_n,
  input  wire [1:0]                addrIn,
  input  wire [`SSS_DATA_W-1:0]    result_bus_in,
  output reg  [`SSS_DATA_W-1:0]    result_bus_out,
  output reg  [`SSS_DATA_W-1:0]    result_bus_oe,
  output reg                       done_n,
  output reg  [3:0]                holdStage,
  output reg                       bankSelect,
  output reg  [1:0]                convChannel,
  output reg                       convStart,
  input  wire [`SSS_DATA_W-1:0]    convResult,
  output reg                       powerDown
);
  // ************************************************************
  // reset release
  // ************************************************************
  reg  rstSync1;
  reg  rstSync2;
  wire rst_n;
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  // two flops, so no register leaves reset on a half-settled edge
  assign rst_n = rstSync2;

  // ************************************************************
  // edge detection of host strobes
  // ************************************************************
  reg  strobePrev;
  reg  writePrev;
  reg  selPrev;
  reg  readPrev;
  wire strobeRise;
  wire modeLatch;
  wire readFall;
  wire readRise;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobePrev <= 1'b1;
      writePrev  <= 1'b1;
      selPrev    <= 1'b1;
      readPrev   <= 1'b1;
    end
    else
    begin
      strobePrev <= sample_strobe_n;
      writePrev  <= write_n;
      selPrev    <= chipSel_n;
      readPrev   <= read_n;
    end
  end
  assign strobeRise = sample_strobe_n & ~strobePrev;
  // write counts while selected; select rise ends a write still low
  assign modeLatch  = (~chipSel_n & write_n & ~writePrev & ~selPrev)
                    | (chipSel_n & ~selPrev & ~writePrev);
  // read strobes only count while selected
  assign readFall   = ~chipSel_n & ~read_n & readPrev;
  assign readRise   = ~chipSel_n & read_n & ~readPrev;

  // ************************************************************
  // mode word register
  // ************************************************************
  reg  [`SSS_MODE_W-1:0] modeWord;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      modeWord <= `SSS_MODE_RESET;
    else if (modeLatch)
      modeWord <= {result_bus_in[1:0], addrIn};
  end
  // top bit wins, others ignored; top bit clear wakes
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      powerDown <= 1'b0;
    else
      powerDown <= modeWord[`SSS_PD_BIT];
  end

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_PUSH = 2'b10;
  reg  [1:0]            state;
  reg  [`SSS_CNT_W-1:0] cycCount;
  reg  [1:0]            lastChan;
  reg                   seqEnd;
  wire                  fifoInReady;
  wire                  fifoOutValid;
  wire [13:0]           fifoOut;
  reg                   fifoInValid;
  reg  [13:0]           fifoIn;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state       <= ST_IDLE;
      cycCount    <= {`SSS_CNT_W{1'b0}};
      lastChan    <= 2'b00;
      holdStage   <= 4'h0;
      bankSelect  <= 1'b0;
      convChannel <= 2'b00;
      convStart   <= 1'b0;
      fifoInValid <= 1'b0;
      fifoIn      <= 14'h0000;
      seqEnd      <= 1'b0;
    end
    else
    begin
      convStart <= 1'b0;
      seqEnd    <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          // powered-down converter ignores starts
          if (strobeRise && !modeWord[`SSS_PD_BIT])
          begin
            holdStage   <= 4'hF;
            bankSelect  <= modeWord[`SSS_BANK_BIT];
            lastChan    <= modeWord[`SSS_CNT_HI:`SSS_CNT_LO];
            convChannel <= 2'b00;
            convStart   <= 1'b1;
            cycCount    <= {`SSS_CNT_W{1'b0}};
            state       <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          // strobe edges are not looked at here
          // push cycle belongs to the slot, keeping each channel at 2us
          if (cycCount == `SSS_CONV_CYC - 2)
          begin
            fifoIn      <= {convChannel, convResult};
            fifoInValid <= 1'b1;
            state       <= ST_PUSH;
          end
          else
            cycCount <= cycCount + 1'b1;
        end
        ST_PUSH:
        begin
          // stall until fifo takes the word
          if (fifoInReady)
          begin
            fifoInValid <= 1'b0;
            cycCount    <= {`SSS_CNT_W{1'b0}};
            if (convChannel == lastChan)
            begin
              holdStage <= 4'h0;
              seqEnd    <= 1'b1;
              state     <= ST_IDLE;
            end
            else
            begin
              convChannel <= convChannel + 1'b1;
              convStart   <= 1'b1;
              state       <= ST_CONV;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // fifo and result memory
  // ************************************************************
  // memory side always takes a word, so the fifo never backs up
  sss_fifo
  #(
    .WIDTH (14),
    .DEPTH (`SSS_FIFO_DEPTH),
    .AW    (2)
  )
  sss_fifo_i
  (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .inData   (fifoIn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (1'b1)
  );

  reg  [`SSS_PTR_W-1:0]  readPtr;
  wire [`SSS_DATA_W-1:0] memData;
  sss_result_mem sss_result_mem_i
  (
    .clk    (ref_clk),
    .wrEn   (fifoOutValid),
    .wrAddr (fifoOut[13:12]),
    .wrData (fifoOut[11:0]),
    .rdAddr (readPtr),
    .rdData (memData)
  );

  // ************************************************************
  // completion flag, read pointer and bus
  // ************************************************************
  reg seqDone;
  // flag waits until the last word has left the fifo
  // set beats a read fall in the same clock, so an end is never lost
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_n  <= 1'b1;
      seqDone <= 1'b0;
    end
    else
    begin
      seqDone <= seqEnd;
      if (seqDone && !fifoOutValid)
        done_n <= 1'b0;
      else if (readFall)
        done_n <= 1'b1;
    end
  end
  // start resets pointer; wraps at four since it is two bits
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      readPtr <= {`SSS_PTR_W{1'b0}};
    else if (strobeRise && state == ST_IDLE && !modeWord[`SSS_PD_BIT])
      readPtr <= {`SSS_PTR_W{1'b0}};
    else if (readRise)
      readPtr <= readPtr + 1'b1;
  end
  // drive while selected and read low; memory data lags one cycle
  // release follows a select rise one clock late
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_bus_out <= {`SSS_DATA_W{1'b0}};
      result_bus_oe  <= {`SSS_DATA_W{1'b0}};
    end
    else
    begin
      result_bus_out <= memData;
      if (!chipSel_n && !read_n && !readFall)
        result_bus_oe <= {`SSS_DATA_W{1'b1}};
      else
        result_bus_oe <= {`SSS_DATA_W{1'b0}};
    end
  end
endmodule // sss_sequencer
`default_nettype wire

// ### rtl/sss_defs.vh
// constants of the simultaneous sample sequencer
`ifndef SSS_DEFS_VH
`define SSS_DEFS_VH
// ************************************************************
// mode word layout
// ************************************************************
`define SSS_MODE_W        4
`define SSS_MODE_RESET    4'h0
`define SSS_PD_BIT        3
`define SSS_BANK_BIT      2
`define SSS_CNT_HI        1
`define SSS_CNT_LO        0
// ************************************************************
// data and memory
// ************************************************************
`define SSS_DATA_W        12
`define SSS_CHANNELS      4
`define SSS_PTR_W         2
// ************************************************************
// timing
// ************************************************************
`define SSS_CLK_NS        25
`define SSS_CONV_NS       2000
`define SSS_CONV_CYC      ((`SSS_CONV_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)
`define SSS_TRACK_NS      600
`define SSS_TRACK_CYC     ((`SSS_TRACK_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)
`define SSS_CNT_W         7
`define SSS_FIFO_DEPTH    4
`endif

// ### rtl/sss_fifo.v
// small valid/ready fifo between the converter and the result memory
`default_nettype none
module sss_fifo
#(
  parameter WIDTH = 14,
  parameter DEPTH = 4,
  parameter AW    = 2
)
(
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  wire            doPush;
  wire            doPop;
  // ************************************************************
  // flags
  // ************************************************************
  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData  = store[rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;
  // storage has no reset, only pointers and count do
  always @(posedge clk)
  begin
    if (doPush)
      store[wrPtr] <= inData;
  end
  // pointers and fill level
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doPush)
        wrPtr <= wrPtr + 1'b1;
      if (doPop)
        rdPtr <= rdPtr + 1'b1;
      if (doPush && !doPop)
        count <= count + 1'b1;
      else if (doPop && !doPush)
        count <= count - 1'b1;
    end
  end
endmodule // sss_fifo
`default_nettype wire

// ### rtl/sss_result_mem.v
// four-word result memory with registered read data
`default_nettype none
`include "sss_defs.vh"
module sss_result_mem
(
  input  wire                      clk,
  input  wire                      wrEn,
  input  wire [`SSS_PTR_W-1:0]     wrAddr,
  input  wire [`SSS_DATA_W-1:0]    wrData,
  input  wire [`SSS_PTR_W-1:0]     rdAddr,
  output reg  [`SSS_DATA_W-1:0]    rdData
);
  reg [`SSS_DATA_W-1:0] words [0:`SSS_CHANNELS-1];
  // write port and registered read port
  always @(posedge clk)
  begin
    if (wrEn)
      words[wrAddr] <= wrData;
    rdData <= words[rdAddr];
  end
endmodule // sss_result_mem
`default_nettype wire

// ### test/sss_sequencer_props.sv
// pin-level assertions of the sequencer
`default_nettype none
module sss_props
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        sample_strobe_n,
  input wire logic        chipSel_n,
  input wire logic        write_n,
  input wire logic        read_n,
  input wire logic [11:0] result_bus_in,
  input wire logic [11:0] result_bus_oe,
  input wire logic        done_n,
  input wire logic [3:0]  holdStage,
  input wire logic [1:0]  convChannel,
  input wire logic        convStart,
  input wire logic        powerDown
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ****
  // properties
  // ****
  start_hold_a:
  assert property ($rose(sample_strobe_n) && holdStage == 4'h0 && !powerDown && $past(arst_n, 3)
    |=> holdStage == 4'hF && convStart && convChannel == 2'h0) else $error("start not held");
  strobe_ignore_a:
  assert property (convStart |-> $past(holdStage) == ((convChannel == 2'h0) ? 4'h0 : 4'hF))
    else $error("start while busy");
  slot_order_a:
  assert property (convStart |-> ##80 (holdStage == 4'h0
    || convStart && convChannel == $past(convChannel, 80) + 2'h1)) else $error("slot wrong");
  done_fall_a:
  assert property ($fell(holdStage[0]) |-> ##2 !done_n) else $error("flag late");
  bus_release_a:
  assert property (chipSel_n && $past(chipSel_n) |-> result_bus_oe == 12'h000)
    else $error("bus driven unselected");
  read_drive_a:
  assert property ($fell(read_n) && !chipSel_n ##1 !read_n && !chipSel_n
    |=> result_bus_oe == 12'hFFF) else $error("bus not driven");
  read_flag_a:
  assert property ($fell(read_n) && !chipSel_n && holdStage == 4'h0 |=> done_n)
    else $error("flag not cleared");
  mode_pd_a:
  assert property ($rose(write_n) && !chipSel_n && !$past(chipSel_n)
    |-> ##2 powerDown == $past(result_bus_in[1], 2)) else $error("mode not taken");
  pd_refuse_a:
  assert property (powerDown && $past(powerDown) && $past(holdStage) == 4'h0 |-> !convStart)
    else $error("start in power-down");
  reset_flag_a:
  assert property (!$past(arst_n) |-> done_n && !powerDown) else $error("reset state");
endmodule // sss_props
bind sss_sequencer sss_props sss_props_i (.ref_clk(ref_clk), .arst_n(arst_n),
  .sample_strobe_n(sample_strobe_n), .chipSel_n(chipSel_n), .write_n(write_n),
  .read_n(read_n), .result_bus_in(result_bus_in), .result_bus_oe(result_bus_oe),
  .done_n(done_n), .holdStage(holdStage), .convChannel(convChannel),
  .convStart(convStart), .powerDown(powerDown));
`default_nettype wire

// ### test/sss_conv_model.sv
// converter stand-in giving a result per bank and channel
`default_nettype none
module sss_conv_model
(
  input  wire logic        ref_clk,
  input  wire logic        convStart,
  input  wire logic        bankSelect,
  input  wire logic [1:0]  convChannel,
  input  wire logic [3:0]  holdStage,
  output var  logic [11:0] convResult
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] code;
  // code marks bank and channel, negative so the top bit is exercised
  always @(posedge ref_clk)
    if (convStart)
      code <= 12'hA00 | {9'h000, bankSelect, convChannel};
  // outside a sequence (hold stages clear) the inverse shows, so a late sample is caught
  assign convResult = (holdStage != 4'h0) ? code : ~code;
endmodule // sss_conv_model
`default_nettype wire

// ### test/tb_simultaneous_sample_sequencer.sv
// self-checking bench of the sequencer and its host bus
`default_nettype none
module tb_simultaneous_sample_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic        refClk, arstN, strobeN, csN, wrN, rdN, doneN, bank, convStart, pd;
  logic [1:0]  addr, chan;
  logic [3:0]  hold;
  logic [11:0] hostBus, busOut, busOe, convResult;
  wire  [11:0] busIn = (busOe != 12'h000) ? busOut : hostBus;
  int          failures, num_checks;
  sss_sequencer sss_sequencer_i (.ref_clk(refClk), .arst_n(arstN), .sample_strobe_n(strobeN),
    .chipSel_n(csN), .write_n(wrN), .read_n(rdN), .addrIn(addr), .result_bus_in(busIn),
    .result_bus_out(busOut), .result_bus_oe(busOe), .done_n(doneN), .holdStage(hold),
    .bankSelect(bank), .convChannel(chan), .convStart(convStart), .convResult(convResult),
    .powerDown(pd));
  sss_conv_model sss_conv_model_i (.ref_clk(refClk), .convStart(convStart),
    .bankSelect(bank), .convChannel(chan), .holdStage(hold), .convResult(convResult));
  // ****
  // bus tasks
  // ****
  task automatic check(input logic [11:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] m, input logic cs);
    csN = cs;
    wrN = 0;
    addr = m[1:0];
    hostBus = {10'h000, m[3:2]};
    @(negedge refClk);
    wrN = 1;
    @(negedge refClk);
    csN = 1;
    hostBus = ~hostBus; // released bus never keeps the old word
    @(negedge refClk);
  endtask
  // select stays low across reads, so back-to-back words are tried
  task automatic rd(input logic [11:0] exp, input bit chk);
    csN = 0;
    rdN = 0;
    repeat (3) @(negedge refClk);
    if (chk) check(busOut, exp, "read word");
    if (chk) check(busOe, 12'hFFF, "bus drive");
    check({11'h000, doneN}, 12'h001, "flag after read");
    rdN = 1;
    @(negedge refClk);
  endtask
  task automatic seq(input int n);
    int cnt;
    cnt = 0;
    repeat (24) @(negedge refClk);
    strobeN = 0;
    @(negedge refClk);
    strobeN = 1;
    while (doneN === 1'b1 && cnt < 500)
    begin
      @(negedge refClk);
      cnt++;
      strobeN = !(cnt == 40); // stray strobe mid-run
    end
    check(12'(cnt), 12'(80 * n + 3), "sequence cycles");
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_modes;
    for (int m = 0; m < 8; m++)
    begin
      if (m > 0) wr(m[3:0], 0);
      seq(m % 4 + 1);
      for (int i = 0; i < 5; i++)
        rd(12'hA00 | {9'h000, m[2], i[1:0]}, i <= m % 4 || i == 4);
      csN = 1;
      @(negedge refClk);
    end
    $display("modes done");
  endtask
  task automatic t_restart;
    rd(12'h000, 0);
    rd(12'h000, 0);
    csN = 1;
    seq(4);
    rd(12'hA04, 1);
    csN = 1;
    @(negedge refClk);
    $display("restart done");
  endtask
  task automatic t_power;
    wr(4'hD, 0);
    check({11'h000, pd}, 12'h001, "power-down");
    strobeN = 0;
    @(negedge refClk);
    strobeN = 1;
    repeat (100) @(negedge refClk);
    check({7'h00, hold, doneN}, 12'h001, "start refused");
    wr(4'h2, 1);
    check({11'h000, pd}, 12'h001, "write unselected");
    rdN = 0;
    repeat (3) @(negedge refClk);
    check(busOe, 12'h000, "read unselected");
    rdN = 1;
    @(negedge refClk);
    // wake word taken by the select rise while write is still low
    csN = 0;
    wrN = 0;
    addr = 2'h0;
    hostBus = 12'h001;
    @(negedge refClk);
    csN = 1;
    @(negedge refClk);
    wrN = 1;
    repeat (2) @(negedge refClk);
    check({11'h000, pd}, 12'h000, "wake");
    seq(1);
    rd(12'hA04, 1);
    csN = 1;
    $display("power done");
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // clock, reset, run
  // ****
  initial
  begin
    refClk = 0;
    forever #12.5 refClk = ~refClk;
  end
  initial
  begin
    arstN = 0;
    strobeN = 1;
    csN = 1;
    wrN = 1;
    rdN = 1;
    addr = 2'h0;
    hostBus = 12'h5A5;
    failures = 0;
    num_checks = 0;
    repeat (5) @(negedge refClk);
    arstN = 1;
    repeat (3) @(negedge refClk);
    check({10'h000, doneN, pd}, 12'h002, "reset state");
    check(busOe, 12'h000, "reset bus");
    t_modes;
    t_restart;
    t_power;
    close_out;
  end
  // watchdog: about eight times the expected run
  initial
  begin
    #500000;
    failures++;
    close_out;
  end
endmodule // tb_simultaneous_sample_sequencer
`default_nettype wire
